// ===== gpio_jkl_consts.svh
// constants for the three-port byte gpio block: addresses, resets, mode codes
`ifndef GPIO_JKL_CONSTS_SVH
`define GPIO_JKL_CONSTS_SVH

// ----------------------------------------------------------------------------
// register addresses (translated alias and untranslated alias)
// ----------------------------------------------------------------------------
`define GJK_ADDR_PORT_A_DATA    32'h0400_0130
`define GJK_ADDR_PORT_B_DATA    32'h0400_0132
`define GJK_ADDR_PORT_C_DATA    32'h0400_0134
`define GJK_ALIAS_UNTRANSLATED  32'ha000_0000
`define GJK_ALIAS_MASK          32'he000_0000

// ----------------------------------------------------------------------------
// reset values and mode codes
// ----------------------------------------------------------------------------
`define GJK_RESET_PORT_A        8'h00
`define GJK_RESET_PORT_B        8'h00
`define GJK_RESET_PORT_C        8'h00
`define GJK_MODE_OTHER          2'h0
`define GJK_MODE_OUTPUT         2'h1
`define GJK_MODE_IN_PULLUP      2'h2
`define GJK_MODE_IN_NOPULL      2'h3

`endif

// ===== gjk_pkg.sv
// package with the types of the three-port byte gpio block
package gjk_pkg;
    typedef enum logic [1:0] {
        GJK_OTHER     = 2'h0,
        GJK_OUTPUT    = 2'h1,
        GJK_IN_PULLUP = 2'h2,
        GJK_IN_NOPULL = 2'h3
    } gjk_mode_t;
    typedef logic [7:0] gjk_byte_t;
endpackage

// ===== gjk_sync.sv
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
`default_nettype none
module gjk_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic             clock_enable,
    // data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_one;
    logic [WIDTH-1:0] next_stage_one;
    logic [WIDTH-1:0] next_sync_out;

    initial begin
        if (WIDTH < 1) begin
            $error("gjk_sync: WIDTH must be at least 1");
        end
    end

    always_comb begin
        next_stage_one = clock_enable ? async_in : stage_one;
        next_sync_out  = clock_enable ? stage_one : sync_out;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stage_one <= '0;
            sync_out  <= '0;
        end else begin
            stage_one <= next_stage_one;
            sync_out  <= next_sync_out;
        end
    end
endmodule
`default_nettype wire

// ===== gjk_ports.sv
// three byte-wide port data registers: two bidirectional ports, one input-only port
//
// Summary of operation
// - port a: 8-bit read/write data register
// - port b: identical 8-bit read/write register
// - output mode reads return register bit
// - input modes read synchronised pin level
// - power-on reset clears port a
// - power-on reset clears port b
// - port a kept through standby, sleep, manual reset
// - port b kept likewise
// - mode 00: register read/write, pin undriven
// - mode 01: write drives pin, read register
// - modes 10/11: read pin, write register only
// - pull-up enable follows external controller in mode 10 only
// - port c input only, read-only, resets zero
// - each register answers at two aliases
// - port c: 00/01 read zero, writes ignored
// - port c pins have no pull-up
`timescale 1ns/1ps
`default_nettype none
`include "gpio_jkl_consts.svh"
module gjk_ports
    import gjk_pkg::*;
#(
    parameter int PORT_WIDTH = 8
) (
    // clock, reset (power-on only) and clock enable
    input  wire logic                    clock,
    input  wire logic                    reset_n,
    input  wire logic                    clock_enable,
    // byte register access port
    input  wire logic [31:0]             reg_addr,
    input  wire logic                    reg_read,
    input  wire logic                    reg_write,
    input  wire logic [7:0]              reg_wdata,
    output logic      [7:0]              reg_rdata,
    output logic                         reg_hit,
    // per-pin mode fields and pull-up controls from the pin-function controller
    input  wire logic [PORT_WIDTH-1:0]   port_a_pin_mode_hi,
    input  wire logic [PORT_WIDTH-1:0]   port_a_pin_mode_lo,
    input  wire logic [PORT_WIDTH-1:0]   port_b_pin_mode_hi,
    input  wire logic [PORT_WIDTH-1:0]   port_b_pin_mode_lo,
    input  wire logic [PORT_WIDTH-1:0]   port_c_pin_mode_hi,
    input  wire logic [PORT_WIDTH-1:0]   port_c_pin_mode_lo,
    input  wire logic [PORT_WIDTH-1:0]   port_a_pullup_request,
    input  wire logic [PORT_WIDTH-1:0]   port_b_pullup_request,
    // pins
    input  wire logic [PORT_WIDTH-1:0]   port_a_pin_in,
    output logic      [PORT_WIDTH-1:0]   port_a_pin_out,
    output logic      [PORT_WIDTH-1:0]   port_a_pin_oe_n,
    output logic      [PORT_WIDTH-1:0]   port_a_pullup_en,
    input  wire logic [PORT_WIDTH-1:0]   port_b_pin_in,
    output logic      [PORT_WIDTH-1:0]   port_b_pin_out,
    output logic      [PORT_WIDTH-1:0]   port_b_pin_oe_n,
    output logic      [PORT_WIDTH-1:0]   port_b_pullup_en,
    input  wire logic [PORT_WIDTH-1:0]   port_c_pin
);
    initial begin
        if (PORT_WIDTH != 8) begin
            $error("gjk_ports: registers are byte wide, PORT_WIDTH must be 8");
        end
    end

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    logic [PORT_WIDTH-1:0] a_pin_sync;
    logic [PORT_WIDTH-1:0] b_pin_sync;
    logic [PORT_WIDTH-1:0] c_pin_sync;

    gjk_sync #(.WIDTH(PORT_WIDTH)) u_sync_a (
        .clock        (clock),
        .reset_n      (reset_n),
        .clock_enable (clock_enable),
        .async_in     (port_a_pin_in),
        .sync_out     (a_pin_sync)
    );
    gjk_sync #(.WIDTH(PORT_WIDTH)) u_sync_b (
        .clock        (clock),
        .reset_n      (reset_n),
        .clock_enable (clock_enable),
        .async_in     (port_b_pin_in),
        .sync_out     (b_pin_sync)
    );
    gjk_sync #(.WIDTH(PORT_WIDTH)) u_sync_c (
        .clock        (clock),
        .reset_n      (reset_n),
        .clock_enable (clock_enable),
        .async_in     (port_c_pin),
        .sync_out     (c_pin_sync)
    );

    // ------------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------------
    // the top three bits pick the alias; both land on the same register
    logic [31:0] phys_addr;
    logic        alias_ok;
    logic        sel_a;
    logic        sel_b;
    logic        sel_c;

    always_comb begin
        phys_addr = reg_addr & ~`GJK_ALIAS_MASK;
        alias_ok  = ((reg_addr & `GJK_ALIAS_MASK) == 32'h0000_0000)
                  || ((reg_addr & `GJK_ALIAS_MASK) == `GJK_ALIAS_UNTRANSLATED);
        sel_a     = alias_ok && (phys_addr == `GJK_ADDR_PORT_A_DATA);
        sel_b     = alias_ok && (phys_addr == `GJK_ADDR_PORT_B_DATA);
        sel_c     = alias_ok && (phys_addr == `GJK_ADDR_PORT_C_DATA);
    end

    // ------------------------------------------------------------------------
    // data registers
    // ------------------------------------------------------------------------
    // only reset_n (power-on) clears them; standby, sleep and manual reset
    // do not reach this block, so contents survive them
    gjk_byte_t bidir_port_a_data;
    gjk_byte_t bidir_port_b_data;
    gjk_byte_t next_bidir_port_a_data;
    gjk_byte_t next_bidir_port_b_data;

    always_comb begin
        next_bidir_port_a_data = bidir_port_a_data;
        next_bidir_port_b_data = bidir_port_b_data;
        if (clock_enable && reg_write && sel_a) begin
            next_bidir_port_a_data = reg_wdata;
        end
        if (clock_enable && reg_write && sel_b) begin
            next_bidir_port_b_data = reg_wdata;
        end
        // writes to port c fall through with no effect
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bidir_port_a_data <= `GJK_RESET_PORT_A;
            bidir_port_b_data <= `GJK_RESET_PORT_B;
        end else begin
            bidir_port_a_data <= next_bidir_port_a_data;
            bidir_port_b_data <= next_bidir_port_b_data;
        end
    end

    // ------------------------------------------------------------------------
    // per-pin read value and pin drive
    // ------------------------------------------------------------------------
    gjk_byte_t         a_view;
    gjk_byte_t         b_view;
    gjk_byte_t         input_port_c_data;
    logic [PORT_WIDTH-1:0] next_a_oe_n;
    logic [PORT_WIDTH-1:0] next_b_oe_n;
    logic [PORT_WIDTH-1:0] next_a_pu;
    logic [PORT_WIDTH-1:0] next_b_pu;

    always_comb begin
        for (int i = 0; i < PORT_WIDTH; i++) begin
            // port a
            unique case (gjk_mode_t'({port_a_pin_mode_hi[i], port_a_pin_mode_lo[i]}))
                GJK_OTHER, GJK_OUTPUT: a_view[i] = bidir_port_a_data[i];
                GJK_IN_PULLUP, GJK_IN_NOPULL: a_view[i] = a_pin_sync[i];
            endcase
            next_a_oe_n[i] = !(!port_a_pin_mode_hi[i] && port_a_pin_mode_lo[i]);
            next_a_pu[i]   = port_a_pullup_request[i] && port_a_pin_mode_hi[i]
                           && !port_a_pin_mode_lo[i];
            // port b
            unique case (gjk_mode_t'({port_b_pin_mode_hi[i], port_b_pin_mode_lo[i]}))
                GJK_OTHER, GJK_OUTPUT: b_view[i] = bidir_port_b_data[i];
                GJK_IN_PULLUP, GJK_IN_NOPULL: b_view[i] = b_pin_sync[i];
            endcase
            next_b_oe_n[i] = !(!port_b_pin_mode_hi[i] && port_b_pin_mode_lo[i]);
            next_b_pu[i]   = port_b_pullup_request[i] && port_b_pin_mode_hi[i]
                           && !port_b_pin_mode_lo[i];
            // port c: input only, no pull-up exists
            input_port_c_data[i] = port_c_pin_mode_hi[i] ? c_pin_sync[i] : 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------------
    gjk_byte_t              next_reg_rdata;
    logic                   next_reg_hit;
    logic [PORT_WIDTH-1:0]  next_a_out;
    logic [PORT_WIDTH-1:0]  next_b_out;

    always_comb begin
        next_reg_rdata = reg_rdata;
        next_reg_hit   = reg_hit;
        next_a_out     = port_a_pin_out;
        next_b_out     = port_b_pin_out;
        if (clock_enable) begin
            next_reg_hit   = (reg_read || reg_write) && (sel_a || sel_b || sel_c);
            next_reg_rdata = 8'h00;
            if (reg_read) begin
                if (sel_a) begin
                    next_reg_rdata = a_view;
                end else if (sel_b) begin
                    next_reg_rdata = b_view;
                end else if (sel_c) begin
                    next_reg_rdata = input_port_c_data;
                end
            end
            // pin follows the register; only output mode enables the driver
            next_a_out = next_bidir_port_a_data;
            next_b_out = next_bidir_port_b_data;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata        <= 8'h00;
            reg_hit          <= 1'b0;
            port_a_pin_out   <= `GJK_RESET_PORT_A;
            port_b_pin_out   <= `GJK_RESET_PORT_B;
            port_a_pin_oe_n  <= '1;
            port_b_pin_oe_n  <= '1;
            port_a_pullup_en <= '0;
            port_b_pullup_en <= '0;
        end else begin
            reg_rdata        <= next_reg_rdata;
            reg_hit          <= next_reg_hit;
            port_a_pin_out   <= next_a_out;
            port_b_pin_out   <= next_b_out;
            if (clock_enable) begin
                port_a_pin_oe_n  <= next_a_oe_n;
                port_b_pin_oe_n  <= next_b_oe_n;
                port_a_pullup_en <= next_a_pu;
                port_b_pullup_en <= next_b_pu;
            end
        end
    end
endmodule
`default_nettype wire

// ===== gjk_ports_asserts.sv
// checker for the three-port byte gpio block
`timescale 1ns/1ps
`default_nettype none
`include "gpio_jkl_consts.svh"
module gjk_ports_asserts (
    // clock and reset
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic        clock_enable,
    // register access
    input wire logic [31:0] reg_addr,
    input wire logic        reg_read,
    input wire logic        reg_write,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_hit,
    // controls and pins
    input wire logic [7:0]  port_a_pin_mode_hi,
    input wire logic [7:0]  port_a_pin_mode_lo,
    input wire logic [7:0]  port_c_pin_mode_hi,
    input wire logic [7:0]  port_a_pullup_request,
    input wire logic [7:0]  port_a_pin_out,
    input wire logic [7:0]  port_a_pin_oe_n,
    input wire logic [7:0]  port_a_pullup_en,
    input wire logic [7:0]  port_b_pin_out
);
    logic ok, sel_a, sel_b, sel_c, mapped;
    // only the two documented alias windows decode
    assign ok = (reg_addr[31:29] == 3'h0) || (reg_addr[31:29] == 3'h5);
    assign sel_a = ok && ({3'h0, reg_addr[28:0]} == `GJK_ADDR_PORT_A_DATA);
    assign sel_b = ok && ({3'h0, reg_addr[28:0]} == `GJK_ADDR_PORT_B_DATA);
    assign sel_c = ok && ({3'h0, reg_addr[28:0]} == `GJK_ADDR_PORT_C_DATA);
    assign mapped = sel_a || sel_b || sel_c;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    property p_hit; clock_enable && (reg_read || reg_write) && mapped |=> reg_hit; endproperty
    a_hit: assert property (p_hit) else $error("no hit after mapped access");
    property p_miss; clock_enable && !mapped |=> !reg_hit && reg_rdata == 8'h00; endproperty
    a_miss: assert property (p_miss) else $error("unmapped access answered");
    property p_wr_a; clock_enable && reg_write && sel_a |=> port_a_pin_out == $past(reg_wdata);
    endproperty
    a_wr_a: assert property (p_wr_a) else $error("port a write lost");
    property p_wr_b; clock_enable && reg_write && sel_b |=> port_b_pin_out == $past(reg_wdata);
    endproperty
    a_wr_b: assert property (p_wr_b) else $error("port b write lost");
    property p_oe_a;
        clock_enable |=> port_a_pin_oe_n == ~$past(~port_a_pin_mode_hi & port_a_pin_mode_lo);
    endproperty
    a_oe_a: assert property (p_oe_a) else $error("port a drive wrong");
    property p_pull_a; clock_enable |=> port_a_pullup_en ==
        $past(port_a_pullup_request & port_a_pin_mode_hi & ~port_a_pin_mode_lo); endproperty
    a_pull_a: assert property (p_pull_a) else $error("port a pull-up wrong");
    property p_c_zero; clock_enable && reg_read && sel_c && port_c_pin_mode_hi == 8'h00
        |=> reg_rdata == 8'h00; endproperty
    a_c_zero: assert property (p_c_zero) else $error("port c read not zero");
    property p_rd_out; clock_enable && reg_read && !reg_write && sel_a &&
        port_a_pin_mode_hi == 8'h00 && port_a_pin_mode_lo == 8'hff
        |=> reg_rdata == port_a_pin_out; endproperty
    a_rd_out: assert property (p_rd_out) else $error("output read not register");
    property p_keep; !clock_enable |=> $stable(port_a_pin_out) && $stable(port_b_pin_out);
    endproperty
    a_keep: assert property (p_keep) else $error("data lost while frozen");
    c_write_a: cover property (clock_enable && reg_write && sel_a);
    c_read_c: cover property (clock_enable && reg_read && sel_c);
    c_freeze: cover property (!clock_enable ##1 clock_enable);
endmodule
bind gjk_ports gjk_ports_asserts u_asserts (.clock(clock), .reset_n(reset_n),
    .clock_enable(clock_enable), .reg_addr(reg_addr), .reg_read(reg_read),
    .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .port_a_pin_mode_hi(port_a_pin_mode_hi), .port_a_pin_mode_lo(port_a_pin_mode_lo),
    .port_c_pin_mode_hi(port_c_pin_mode_hi), .port_a_pullup_request(port_a_pullup_request),
    .port_a_pin_out(port_a_pin_out), .port_a_pin_oe_n(port_a_pin_oe_n),
    .port_a_pullup_en(port_a_pullup_en), .port_b_pin_out(port_b_pin_out));
`default_nettype wire

// ===== test_gjk_ports.sv
// self-checking testbench for the three-port byte gpio block
`timescale 1ns/1ps
`default_nettype none
`include "gpio_jkl_consts.svh"
module test_gjk_ports import gjk_pkg::*; ;
    localparam logic [31:0] A = `GJK_ADDR_PORT_A_DATA;
    localparam logic [31:0] B = `GJK_ADDR_PORT_B_DATA;
    localparam logic [31:0] C = `GJK_ADDR_PORT_C_DATA;
    localparam logic [31:0] U = `GJK_ALIAS_UNTRANSLATED;
    logic clock, reset_n, clock_enable, reg_read, reg_write, reg_hit;
    logic [31:0] reg_addr;
    gjk_byte_t reg_wdata, reg_rdata, a_hi, a_lo, b_hi, b_lo, c_hi, c_lo, a_req, b_req;
    gjk_byte_t a_in, b_in, c_in, a_out, a_oe, a_pu, b_out, b_oe, b_pu;
    int n_mismatch = 0;
    int cmp_count = 0;
    gjk_ports DUT (.clock(clock), .reset_n(reset_n), .clock_enable(clock_enable),
        .reg_addr(reg_addr), .reg_read(reg_read), .reg_write(reg_write),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
        .port_a_pin_mode_hi(a_hi), .port_a_pin_mode_lo(a_lo), .port_b_pin_mode_hi(b_hi),
        .port_b_pin_mode_lo(b_lo), .port_c_pin_mode_hi(c_hi), .port_c_pin_mode_lo(c_lo),
        .port_a_pullup_request(a_req), .port_b_pullup_request(b_req),
        .port_a_pin_in(a_in), .port_a_pin_out(a_out), .port_a_pin_oe_n(a_oe),
        .port_a_pullup_en(a_pu), .port_b_pin_in(b_in), .port_b_pin_out(b_out),
        .port_b_pin_oe_n(b_oe), .port_b_pullup_en(b_pu), .port_c_pin(c_in));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task automatic complete_run;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input gjk_byte_t seen, input gjk_byte_t exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one call per cycle, so no strobe is assigned twice in a time step
    task automatic acc(input logic rd, input logic wr, input logic [31:0] ad, input gjk_byte_t wd);
        reg_read = rd;
        reg_write = wr;
        reg_addr = ad;
        reg_wdata = wd;
        @(posedge clock);
        #1;
    endtask
    task automatic rd_chk(input logic [31:0] ad, input gjk_byte_t exp);
        acc(1'b1, 1'b0, ad, 8'h00);
        chk(reg_rdata, exp);
        chk({7'h00, reg_hit}, 8'h01);
    endtask
    // pins pass two sync flops, so settle three cycles before reading them
    task automatic idle3;
        repeat (3) acc(1'b0, 1'b0, 32'h0, 8'h00);
    endtask
    task automatic t_reset;
        rd_chk(A, 8'h00);
        rd_chk(B, 8'h00);
        rd_chk(C, 8'h00);
        chk(a_oe, 8'hff);
        $display("t_reset done");
    endtask
    task automatic t_port_a;
        {a_hi, a_lo, a_req, a_in} = {8'h0f, 8'h35, 8'hff, 8'ha5};
        acc(1'b0, 1'b1, U | A, 8'h5a);
        chk(a_out, 8'h5a);
        idle3();
        chk(a_oe, 8'hcf);
        chk(a_pu, 8'h0a);
        rd_chk(A, 8'h55);
        acc(1'b0, 1'b1, A, 8'hff);
        {a_hi, a_lo} = {8'h00, 8'hff};
        rd_chk(A, 8'hff);
        $display("t_port_a done");
    endtask
    task automatic t_port_b;
        {b_hi, b_lo, b_in, b_req} = {8'h00, 8'hff, 8'h3c, 8'h0f};
        acc(1'b0, 1'b1, B, 8'hc3);
        rd_chk(U | B, 8'hc3);
        chk(b_oe, 8'h00);
        {b_hi, b_lo} = {8'hff, 8'h00};
        idle3();
        chk(b_oe, 8'hff);
        chk(b_pu, 8'h0f);
        chk(b_out, 8'hc3);
        rd_chk(B, 8'h3c);
        {b_hi, b_lo} = {8'h00, 8'hff};
        $display("t_port_b done");
    endtask
    task automatic t_port_c;
        // low mode bits mixed so that all four port c modes are visited
        {c_in, c_hi, c_lo} = {8'h96, 8'h00, 8'hcc};
        acc(1'b0, 1'b1, C, 8'hff);
        idle3();
        rd_chk(C, 8'h00);
        c_hi = 8'hf0;
        rd_chk(U | C, 8'h90);
        acc(1'b1, 1'b0, C + 32'h2, 8'h00);
        chk({reg_rdata[7:1], reg_hit}, 8'h00);
        acc(1'b1, 1'b0, 32'h4000_0000 | A, 8'h00);
        chk({reg_rdata[7:1], reg_hit}, 8'h00);
        $display("t_port_c done");
    endtask
    task automatic t_hold;
        clock_enable = 1'b0;
        acc(1'b0, 1'b1, A, 8'h11);
        acc(1'b0, 1'b1, B, 8'h22);
        clock_enable = 1'b1;
        rd_chk(A, 8'hff);
        rd_chk(B, 8'hc3);
        reset_n = 1'b0;
        acc(1'b0, 1'b0, 32'h0, 8'h00);
        reset_n = 1'b1;
        rd_chk(A, 8'h00);
        rd_chk(B, 8'h00);
        $display("t_hold done");
    endtask
    initial begin
        // the block must run from the start, so the clock enable is raised with reset
        reset_n = 1'b0;
        clock_enable = 1'b1;
        {reg_read, reg_write, reg_addr, reg_wdata} = '0;
        {a_hi, a_lo, b_hi, b_lo, c_hi, c_lo, a_req, b_req, a_in, b_in, c_in} = '0;
        repeat (16) @(posedge clock);
        #1;
        reset_n = 1'b1;
        t_reset();
        t_port_a();
        t_port_b();
        t_port_c();
        t_hold();
        complete_run();
    end
    initial begin
        #1_000_000;
        n_mismatch++;
        complete_run();
    end
endmodule
`default_nettype wire
